/* design/host_serial_port.sv */
// host-facing spi / i2c serial port of one die
// Functional notes
// - spi uses mode zero: sample on rising clock, shift out on falling clock
// - every spi packet is exactly sixteen bits, decoded as one unit
// - bit 15 must be one to mark a packet start
// - bit 14 chooses direction: one read, zero write
// - bit 13 marks payload as address (one) or data (zero)
// - bits 11 to 4 carry the eight-bit payload
// - bits 3 to 1 are ignored by the device
// - bit 0 must be one; otherwise the packet is discarded
// - single reads and burst reads of consecutive registers are supported
// - only single writes; a second data write is refused
// - in i2c mode the die answers address 0x64 or 0x66
// - i2c slave address is seven bits, sent first in each transaction
// - shared pin is i2c address pick or active-low spi chip select
// - shared pin is interrupt output by default, test clock input in test
// - shared data pin is i2c data or spi data out
`timescale 1ns/1ps
`default_nettype none

module host_serial_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic spi_clk,
  input wire logic iface_select_pin,
  input wire logic addr_pick_or_chip_select,
  input wire logic serial_data_in_pin,
  input wire logic serial_data_out_pin_i,
  output logic serial_data_out_pin_o,
  output logic serial_data_out_pin_oe,
  input wire logic irq_or_test_clock_pin_i,
  output logic irq_or_test_clock_pin_o,
  output logic irq_or_test_clock_pin_oe,
  input wire logic irq_req,
  input wire logic test_mode,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  output logic pkt_drop,
  output logic wr_refused,
  output logic i2c_addr_match,
  output logic test_clock_level
);

  // ==========================================================================
  // spi clock domain
  logic cs_idle;
  logic [3:0] bit_cnt_q;
  logic [14:0] shift_q;
  logic [15:0] pkt_word_q;
  logic pkt_tgl_q;
  logic miso_q;
  logic [7:0] tx_byte_q;
  logic [15:0] tx_frame;

  // frame ends when chip select rises or the die leaves spi mode
  assign cs_idle = addr_pick_or_chip_select | ~iface_select_pin;
  assign tx_frame = {host_port_pkg::PAD_NIBBLE, tx_byte_q, host_port_pkg::PAD_NIBBLE};

  // bit counter and shifter, cleared by the frame's own chip select
  always_ff @(posedge spi_clk or posedge cs_idle) begin
    if (cs_idle) begin
      bit_cnt_q <= host_port_pkg::CNT_ZERO;
      shift_q <= 15'h0000;
    end else begin
      bit_cnt_q <= bit_cnt_q + host_port_pkg::CNT_ONE;
      shift_q <= {shift_q[13:0], serial_data_in_pin};
    end
  end

  // a whole packet is handed over with a toggle
  always_ff @(posedge spi_clk or negedge nrst) begin
    if (!nrst) begin
      pkt_word_q <= 16'h0000;
      pkt_tgl_q <= 1'b0;
    end else if (!cs_idle && bit_cnt_q == host_port_pkg::CNT_LAST) begin
      pkt_word_q <= {shift_q, serial_data_in_pin};
      pkt_tgl_q <= ~pkt_tgl_q;
    end
  end

  // reply bit changes on the falling clock, msb first
  always_ff @(negedge spi_clk or posedge cs_idle) begin
    if (cs_idle) begin
      miso_q <= 1'b0;
    end else begin
      miso_q <= tx_frame[host_port_pkg::CNT_LAST - bit_cnt_q];
    end
  end

  // ==========================================================================
  // synchronisers into the system clock domain
  logic [host_port_pkg::SYNC_W-1:0] sync_in;
  logic [host_port_pkg::SYNC_W-1:0] sync1_q;
  logic [host_port_pkg::SYNC_W-1:0] sync2_q;
  logic tgl_s, miso_s, cs_s, spi_s, scl_s, sda_s, tclk_s;

  assign sync_in = {pkt_tgl_q, miso_q, addr_pick_or_chip_select, iface_select_pin,
                    spi_clk, serial_data_out_pin_i, irq_or_test_clock_pin_i};
  assign {tgl_s, miso_s, cs_s, spi_s, scl_s, sda_s, tclk_s} = sync2_q;

  genvar gi;
  generate
    for (gi = 0; gi < host_port_pkg::SYNC_W; gi++) begin : g_sync
      // two-flop synchroniser per input
      always_ff @(posedge clk) begin
        if (!nrst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= sync_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // packet decode
  logic tgl_seen_q;
  logic pkt_evt;
  logic pkt_ok;
  logic [7:0] payload;
  host_port_pkg::link_state_e state_q;
  logic [7:0] addr_q;
  logic rd_stb_q, wr_stb_q, drop_q, refused_q;
  logic [7:0] wr_data_q;

  assign pkt_evt = tgl_s ^ tgl_seen_q;
  // start and end markers both set, bits 3..1 not looked at
  assign pkt_ok = pkt_word_q[host_port_pkg::BIT_START] & pkt_word_q[host_port_pkg::BIT_END]
                  & spi_s;
  assign payload = pkt_word_q[host_port_pkg::PAY_HI:host_port_pkg::PAY_LO];

  // packet toggle edge detect
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tgl_seen_q <= 1'b0;
    end else begin
      tgl_seen_q <= tgl_s;
    end
  end

  // transaction state, address and strobes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= host_port_pkg::ST_IDLE;
      addr_q <= host_port_pkg::BYTE_ZERO;
      wr_data_q <= host_port_pkg::BYTE_ZERO;
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      drop_q <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      rd_stb_q <= 1'b0;
      wr_stb_q <= 1'b0;
      drop_q <= 1'b0;
      refused_q <= 1'b0;
      if (pkt_evt && !pkt_ok) begin
        drop_q <= 1'b1;
      end else if (pkt_evt && pkt_word_q[host_port_pkg::BIT_AD]) begin
        addr_q <= payload;
        if (pkt_word_q[host_port_pkg::BIT_RW]) begin
          rd_stb_q <= 1'b1;
          state_q <= host_port_pkg::ST_RD;
        end else begin
          state_q <= host_port_pkg::ST_ADDR;
        end
      end else if (pkt_evt) begin
        unique case (state_q)
          host_port_pkg::ST_ADDR: begin
            if (!pkt_word_q[host_port_pkg::BIT_RW]) begin
              wr_stb_q <= 1'b1;
              wr_data_q <= payload;
              state_q <= host_port_pkg::ST_WR_DONE;
            end else begin
              refused_q <= 1'b1;
            end
          end
          host_port_pkg::ST_RD: begin
            if (pkt_word_q[host_port_pkg::BIT_RW]) begin
              addr_q <= addr_q + host_port_pkg::ADDR_STEP;
              rd_stb_q <= 1'b1;
            end else begin
              refused_q <= 1'b1;
            end
          end
          host_port_pkg::ST_IDLE, host_port_pkg::ST_WR_DONE: begin
            refused_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // read data is loaded the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_byte_q <= host_port_pkg::BYTE_ZERO;
    end else if (rd_stb_q) begin
      tx_byte_q <= reg_rd_data;
    end
  end

  // ==========================================================================
  // i2c address phase
  logic scl_d_q, sda_d_q;
  logic i2c_act_q, i2c_match_q, ack_q;
  logic [3:0] i2c_cnt_q;
  logic [7:0] i2c_sr_q;
  logic i2c_start, i2c_stop, scl_rise, scl_fall;
  logic [6:0] own_addr;

  assign i2c_start = !spi_s && scl_s && scl_d_q && sda_d_q && !sda_s;
  assign i2c_stop = !spi_s && scl_s && scl_d_q && !sda_d_q && sda_s;
  assign scl_rise = scl_s && !scl_d_q;
  assign scl_fall = !scl_s && scl_d_q;
  // address pick pin chooses between the two die addresses
  assign own_addr = cs_s ? host_port_pkg::I2C_ADDR_B : host_port_pkg::I2C_ADDR_A;

  // delayed copies for edge detection
  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      scl_d_q <= scl_s;
      sda_d_q <= sda_s;
    end
  end

  // address shift, compare and acknowledge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      i2c_act_q <= 1'b0;
      i2c_match_q <= 1'b0;
      ack_q <= 1'b0;
      i2c_cnt_q <= host_port_pkg::CNT_ZERO;
      i2c_sr_q <= host_port_pkg::BYTE_ZERO;
    end else if (i2c_start) begin
      i2c_act_q <= 1'b1;
      i2c_match_q <= 1'b0;
      ack_q <= 1'b0;
      i2c_cnt_q <= host_port_pkg::CNT_ZERO;
    end else if (i2c_stop || spi_s) begin
      i2c_act_q <= 1'b0;
      i2c_match_q <= 1'b0;
      ack_q <= 1'b0;
    end else if (i2c_act_q) begin
      if (scl_rise && i2c_cnt_q < host_port_pkg::I2C_DONE_CNT) begin
        i2c_cnt_q <= i2c_cnt_q + host_port_pkg::CNT_ONE;
        if (i2c_cnt_q < host_port_pkg::I2C_ACK_CNT) begin
          i2c_sr_q <= {i2c_sr_q[6:0], sda_s};
        end
      end
      if (scl_fall && i2c_cnt_q == host_port_pkg::I2C_ACK_CNT
          && i2c_sr_q[7:1] == own_addr) begin
        ack_q <= 1'b1;
        i2c_match_q <= 1'b1;
      end else if (scl_fall && i2c_cnt_q == host_port_pkg::I2C_DONE_CNT) begin
        ack_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // pin drivers and outputs
  // data pin: spi reply while selected in spi mode, released while deselected, i2c acknowledge in i2c mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      serial_data_out_pin_o <= 1'b0;
      serial_data_out_pin_oe <= 1'b0;
    end else if (spi_s) begin
      serial_data_out_pin_o <= miso_s;
      serial_data_out_pin_oe <= !cs_s;
    end else begin
      serial_data_out_pin_o <= 1'b0;
      serial_data_out_pin_oe <= ack_q;
    end
  end

  // interrupt pin unless test mode turns it into a clock input
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_or_test_clock_pin_o <= 1'b0;
      irq_or_test_clock_pin_oe <= 1'b0;
      test_clock_level <= 1'b0;
    end else begin
      irq_or_test_clock_pin_o <= irq_req;
      irq_or_test_clock_pin_oe <= !test_mode;
      test_clock_level <= test_mode & tclk_s;
    end
  end

  assign reg_addr = addr_q;
  assign reg_wr_data = wr_data_q;
  assign reg_wr_stb = wr_stb_q;
  assign reg_rd_stb = rd_stb_q;
  assign pkt_drop = drop_q;
  assign wr_refused = refused_q;
  assign i2c_addr_match = i2c_match_q;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  bad_end_drop_a: assert property (pkt_evt && spi_s && !pkt_word_q[0] |=> pkt_drop)
    else $error("packet without end marker not dropped");
  no_start_no_wr_a: assert property (pkt_evt && !pkt_word_q[15] |=> !reg_wr_stb && !reg_rd_stb)
    else $error("packet without start marker acted on");
  rd_addr_take_a: assert property (pkt_evt && pkt_ok && pkt_word_q[13] && pkt_word_q[14]
      |=> reg_rd_stb && reg_addr == $past(payload))
    else $error("read address packet not executed");
  single_wr_a: assert property (reg_wr_stb |-> ##1 (!reg_wr_stb)[*3])
    else $error("back to back write strobes");
  burst_wr_ref_a: assert property (pkt_evt && pkt_ok && !pkt_word_q[13] && !pkt_word_q[14]
      && state_q == host_port_pkg::ST_WR_DONE |=> wr_refused && !reg_wr_stb)
    else $error("second data write not refused");
  burst_rd_inc_a: assert property (pkt_evt && pkt_ok && !pkt_word_q[13] && pkt_word_q[14]
      && state_q == host_port_pkg::ST_RD |=> reg_rd_stb && reg_addr == $past(reg_addr) + 8'h01)
    else $error("burst read did not advance address");
  i2c_ack_own_a: assert property ($rose(ack_q) |-> i2c_sr_q[7:1] == own_addr && !spi_s)
    else $error("acknowledged a foreign i2c address");
  spi_drive_a: assert property (spi_s && !cs_s ##1 spi_s && !cs_s |-> serial_data_out_pin_oe)
    else $error("data out not driven while selected");
  irq_pin_a: assert property (!test_mode ##1 test_mode |=> !irq_or_test_clock_pin_oe)
    else $error("interrupt pin still driven in test mode");

  wr_seen_c: cover property (reg_wr_stb);
  burst_rd_c: cover property (reg_rd_stb ##[1:1000] reg_rd_stb);
  drop_seen_c: cover property (pkt_drop);
  i2c_hit_c: cover property ($rose(i2c_addr_match));

endmodule

`default_nettype wire

/* include/host_port_pkg.sv */
// constants, field positions and states shared by the host serial port
package host_port_pkg;

  // ==========================================================================
  // spi packet layout
  localparam int PKT_BITS = 16;
  localparam int BIT_START = 15;
  localparam int BIT_RW = 14;
  localparam int BIT_AD = 13;
  localparam int BIT_RSVD = 12;
  localparam int PAY_HI = 11;
  localparam int PAY_LO = 4;
  localparam int BIT_END = 0;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_LAST = 4'hF;
  localparam logic [3:0] PAD_NIBBLE = 4'h0;

  // ==========================================================================
  // spi serial clock limits, for reference by the bench
  localparam int SCK_MIN_KHZ = 500;
  localparam int SCK_MAX_KHZ = 2000;

  // ==========================================================================
  // i2c addressing
  localparam logic [6:0] I2C_ADDR_A = 7'h64;
  localparam logic [6:0] I2C_ADDR_B = 7'h66;
  localparam logic [3:0] I2C_ACK_CNT = 4'h8;
  localparam logic [3:0] I2C_DONE_CNT = 4'h9;

  // ==========================================================================
  // misc values
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] ADDR_STEP = 8'h01;
  localparam int SYNC_W = 7;

  // link transaction state
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_WR_DONE = 2'b10,
    ST_RD = 2'b11
  } link_state_e;

endpackage

/* dv/host_master_model.sv */
// host microcontroller model driving the spi and i2c pins of one die
`timescale 1ns/1ps
`default_nettype none

module host_master_model (
  output logic sck,
  output logic cs_n,
  output logic sel,
  output logic mosi,
  output logic sda_low,
  input wire logic miso,
  input wire logic sda_level
);
  // half period of the serial clock; far above a real host's rate to keep runs short
  localparam real HALF = 7.5;
  logic [15:0] rx_word;
  logic ack_seen;

  // ==========================================================================
  // idle levels: clock parked low, die deselected
  initial begin
    sck = 1'b0;
    cs_n <= 1'b1; // late update gives the frame reset a clean edge at time zero
    sel <= 1'b1;
    mosi = 1'b1;
    sda_low = 1'b0;
    rx_word = 16'h0000;
    ack_seen = 1'b0;
  end

  // select spi on the die and let the level settle
  task automatic set_spi;
    cs_n = 1'b1;
    sel = 1'b1;
    #200;
  endtask

  // one frame, msb first, data changed after each falling clock
  task automatic send_pkt(input logic [15:0] w, input int cut);
    int i;
    #3.1;
    cs_n = 1'b0;
    mosi = w[15];
    #(HALF);
    for (i = 0; i < cut; i++) begin
      sck = 1'b1;
      #(HALF);
      sck = 1'b0;
      #2;
      rx_word = {rx_word[14:0], miso};
      if (i < 15) mosi = w[14 - i];
      #(HALF - 2);
    end
    cs_n = 1'b1;
    mosi = ~mosi; // released line does not keep its last value
  endtask

  // start, seven-bit address with rw, ack clock, stop
  task automatic i2c_addr(input logic pick, input logic [6:0] a);
    logic [7:0] b;
    int i;
    b = {a, 1'b0};
    cs_n = pick;
    sel = 1'b0;
    sck = 1'b1;
    #100;
    sda_low = 1'b1;
    #100;
    for (i = 0; i < 9; i++) begin
      sck = 1'b0;
      #50;
      sda_low = (i < 8) ? ~b[7 - i] : 1'b0;
      #50;
      sck = 1'b1;
      #100;
      if (i == 8) ack_seen = ~sda_level;
    end
    sck = 1'b0;
    #50;
    sda_low = 1'b1;
    #50;
    sck = 1'b1;
    #100;
    sda_low = 1'b0;
    #100; // bus left idle with clock high, no zero-width pulse into the next call
  endtask
endmodule

`default_nettype wire

/* dv/tb_host_serial_port.sv */
// self-checking bench for the host serial port with a host model
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module tb_host_serial_port;
  logic clk, nrst, irq_req, test_mode, tclk_pin;
  wire logic sck, cs_n, sel, mosi, sda_low, sda_level;
  logic miso, sdo_oe, irq_o, irq_oe, wr_stb, rd_stb, drop, refused, match_o, tclk_lvl;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [7:0] mem [256];
  int num_errors, samples_checked, seed, n_wr, n_rd, n_drop, n_ref, n_match, st, i, j;
  logic [7:0] m_addr, m_byte, wr_seen;

  assign sda_level = ~(sda_low | (sdo_oe & ~miso));
  assign reg_rd_data = mem[reg_addr];

  host_serial_port u_dut (.clk(clk), .nrst(nrst), .spi_clk(sck), .iface_select_pin(sel),
    .addr_pick_or_chip_select(cs_n), .serial_data_in_pin(mosi),
    .serial_data_out_pin_i(sda_level), .serial_data_out_pin_o(miso),
    .serial_data_out_pin_oe(sdo_oe), .irq_or_test_clock_pin_i(tclk_pin),
    .irq_or_test_clock_pin_o(irq_o), .irq_or_test_clock_pin_oe(irq_oe), .irq_req(irq_req),
    .test_mode(test_mode), .reg_rd_data(reg_rd_data), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(wr_stb), .reg_rd_stb(rd_stb), .pkt_drop(drop),
    .wr_refused(refused), .i2c_addr_match(match_o), .test_clock_level(tclk_lvl));

  host_master_model u_host (.sck(sck), .cs_n(cs_n), .sel(sel), .mosi(mosi),
    .sda_low(sda_low), .miso(miso), .sda_level(sda_level));

  // ==========================================================================
  // clock and event counting
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (wr_stb !== 1'b0) begin
      n_wr++;
      wr_seen = reg_wr_data;
    end
    if (rd_stb !== 1'b0) n_rd++;
    if (drop !== 1'b0) n_drop++;
    if (refused !== 1'b0) n_ref++;
    if (match_o !== 1'b0) n_match++;
  end

  // ==========================================================================
  // send one frame, predict its effect and compare
  task automatic frame(input logic [15:0] w, input int cut);
    int e_wr, e_rd, e_drop, e_ref;
    logic [7:0] pay, rd_prev;
    logic rd_data_pkt;
    e_wr = 0;
    e_rd = 0;
    e_drop = 0;
    e_ref = 0;
    pay = w[11:4];
    rd_prev = m_byte;
    rd_data_pkt = 1'b0;
    n_wr = 0;
    n_rd = 0;
    n_drop = 0;
    n_ref = 0;
    if (cut < 16) begin
      e_wr = 0;
    end else if (!w[15] || !w[0]) begin
      e_drop = 1;
    end else if (w[13]) begin
      m_addr = pay;
      st = w[14] ? 3 : 1;
      e_rd = w[14] ? 1 : 0;
      if (w[14]) m_byte = mem[pay];
    end else if (w[14] && st == 3) begin
      m_addr = m_addr + 8'h01;
      e_rd = 1;
      m_byte = mem[m_addr];
      rd_data_pkt = 1'b1;
    end else if (!w[14] && st == 1) begin
      e_wr = 1;
      st = 2;
    end else begin
      e_ref = 1;
    end
    u_host.send_pkt(w, cut);
    repeat (100) @(posedge clk);
    `CHK("wr_stb", e_wr, n_wr)
    `CHK("rd_stb", e_rd, n_rd)
    `CHK("drop", e_drop, n_drop)
    `CHK("refused", e_ref, n_ref)
    `CHK("reg_addr", m_addr, reg_addr)
    if (e_wr == 1) `CHK("wr_data", pay, wr_seen)
    if (rd_data_pkt) `CHK("miso_byte", rd_prev, u_host.rx_word[11:4])
    if (rd_data_pkt) `CHK("miso_pad", 4'h0, u_host.rx_word[15:12])
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end

  // ==========================================================================
  // main sequence
  initial begin
    seed = 69;
    num_errors = 0;
    samples_checked = 0;
    st = 0;
    m_addr = 8'h00;
    m_byte = 8'h00;
    nrst <= 1'b0; // late update so the link-side reset sees its falling edge
    irq_req = 1'b0;
    test_mode = 1'b0;
    tclk_pin = 1'b0;
    for (i = 0; i < 256; i++) mem[i] = 8'($random(seed));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    for (i = 0; i < 8; i++) begin
      irq_req <= 1'($random(seed));
      @(posedge clk);
      @(posedge clk);
      #1;
      `CHK("irq_pin", irq_req, irq_o)
      `CHK("irq_oe", 1'b1, irq_oe)
    end
    @(posedge clk);
    test_mode <= 1'b1;
    tclk_pin <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    `CHK("irq_oe_test", 1'b0, irq_oe)
    `CHK("test_clk", 1'b1, tclk_lvl)
    u_host.set_spi();
    frame(16'h8121, 16);
    frame(16'hA0B1 | 16'($random(seed) & 32'hE), 16);
    frame(16'h8121, 16);
    frame(16'h8341, 16);
    frame(16'hE0B0, 16);
    frame(16'h60B1, 16);
    frame(16'hE0B1, 7);
    frame(16'hEFD1, 16);
    for (i = 0; i < 4; i++) frame(16'hC001 | 16'($random(seed) & 32'hE), 16);
    frame(16'h8551, 16);
    for (i = 0; i < 10; i++) frame(16'($random(seed)) & 16'hEFFF, 16);
    for (i = 0; i < 2; i++) begin
      for (j = 0; j < 3; j++) begin
        n_match = 0;
        u_host.i2c_addr(i[0], (j == 0) ? 7'h64 : ((j == 1) ? 7'h66 : 7'h23));
        `CHK("i2c_ack", (i == j) ? 1'b1 : 1'b0, u_host.ack_seen)
        `CHK("i2c_match", (i == j) ? 1 : 0, (n_match > 0) ? 1 : 0)
      end
    end
    wrap_up();
  end
endmodule

`default_nettype wire
